// >>> verilog/roc_pkg.sv
// Constants, field layouts and carrier types for the oscillator control block
package roc_pkg;
   // Register indices; byte address is four times the index
   localparam logic [5:0] OSC_CTRL_IDX = 6'h05;
   localparam logic [5:0] OSC_CFG_IDX = 6'h06;
   localparam logic [5:0] PIN_CFG_IDX = 6'h07;
   localparam logic [5:0] IRQ_STAT_IDX = 6'h08;
   localparam logic [5:0] IRQ_CLR_IDX = 6'h09;
   localparam logic [5:0] IRQ_EN_IDX = 6'h0A;
   // Field positions, oscillator control
   localparam int CTRL_GAIN_BIT = 7;
   localparam int CTRL_MODE_BIT = 6;
   localparam int CTRL_BIAS_BIT = 5;
   localparam int CTRL_VALID_BIT = 4;
   localparam int CTRL_LFO_BIT = 3;
   // Field positions, oscillator configuration
   localparam int CFG_STEP_BIT = 7;
   localparam int CFG_READY_BIT = 6;
   // Field positions, pin configuration
   localparam int PIN_SHORT_BIT = 7;
   // Interrupt event bits
   localparam int EV_CAP_READY = 0;
   localparam int EV_AMP_UP = 1;
   localparam int EV_AMP_LOST = 2;
   localparam int EV_W = 3;
   // Values after reset
   localparam logic [3:0] LOAD_CAP_RESET = 4'h0;
   localparam logic [6:0] PIN_RSVD_RESET = 7'h00;
   localparam logic [EV_W-1:0] IRQ_RESET = 3'h0;
   // Stepping pace: one capacitance step per interval
   localparam int CLK_PERIOD_NS = 4;
   localparam int STEP_TIME_NS = 1000;
   localparam int STEP_CYCLES = STEP_TIME_NS / CLK_PERIOD_NS;
   localparam logic [7:0] STEP_LAST = 8'(STEP_CYCLES - 1);
   // Bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Software-visible oscillator control fields
   typedef struct packed {
      logic gainEn;
      logic crystalMode;
      logic biasDouble;
      logic lfoSel;
   } roc_ctrl_t;
   // Load capacitance configuration fields
   typedef struct packed {
      logic autoStep;
      logic [3:0] target;
   } roc_cfg_t;
   // Pending bus write
   typedef struct packed {
      logic [5:0] idx;
      logic [7:0] data;
      logic lane0;
   } roc_wr_t;
   // Decodes a byte address to a word index
   function automatic logic [5:0] wordIndex(input logic [7:0] addr);
      wordIndex = addr[7:2];
   endfunction : wordIndex
endpackage : roc_pkg

// >>> verilog/roc_osc_control.sv
// Oscillator control and status registers with capacitance stepping, AXI4-Lite slave
// What this block does
// - Control bit 7 enables oscillator gain control
// - Control bit 6 picks crystal or self-oscillate
// - Control bit 5 enables bias doubling
// - Control bit 4 reads oscillation amplitude valid
// - Control bit 3 selects low-frequency oscillator, overriding
// - Control bits 2:0 read zero, ignore writes
// - Configuration bit 7 enables capacitance stepping
// - Configuration bit 6 reads target reached
// - Configuration bits 5:4 read zero, ignore writes
// - Configuration bits 3:0 hold target capacitance code
// - Pin bit 7 shorts both crystal pins
// - Registers decode at indices 05 through 0A; a write to index 08 gets SLVERR
`timescale 1ns/1ps
`default_nettype none
module roc_osc_control (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // AXI4-Lite write address and data
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // AXI4-Lite write response
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Analog oscillator side
   input wire logic oscAmplitudeOk,
   output logic oscGainControlEn,
   output logic oscCrystalModeSel,
   output logic oscBiasDoubleEn,
   output logic lowfreqOscSelect,
   output logic [3:0] appliedLoadCap,
   output logic crystalPinsShort,
   // Interrupt
   output logic irq
);
   // Register state
   roc_pkg::roc_ctrl_t ctrl_reg, ctrl_next; // Oscillator control fields
   roc_pkg::roc_cfg_t cfg_reg, cfg_next; // Stepping enable and target
   logic pinShort_reg, pinShort_next; // Crystal pin short
   logic [6:0] pinRsvd_reg, pinRsvd_next; // Reserved pin bits, kept for read-back
   logic [roc_pkg::EV_W-1:0] irqStat_reg, irqStat_next; // Sticky events
   logic [roc_pkg::EV_W-1:0] irqEn_reg, irqEn_next; // Event enables
   // Oscillator side state
   logic ampMeta_reg; // First synchroniser stage, read only by the second
   logic ampSync_reg; // Amplitude level in the clock domain
   logic ampPrev_reg; // Last amplitude level, for edge events
   logic [3:0] applied_reg, applied_next; // Capacitance code actually driven
   logic [7:0] stepCnt_reg, stepCnt_next; // Step pacing divider
   logic readyPrev_reg; // Last target-reached level
   logic srcCrystal_reg, srcCrystal_next; // Effective crystal mode after override
   logic irq_reg, irq_next;
   // Bus state
   logic awHeld_reg, awHeld_next;
   logic wHeld_reg, wHeld_next;
   roc_pkg::roc_wr_t wr_reg, wr_next; // Write pending until both halves arrive
   logic bvalid_reg, bvalid_next;
   logic [1:0] bresp_reg, bresp_next;
   logic rvalid_reg, rvalid_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0] rresp_reg, rresp_next;
   // Decode helpers
   logic doWrite; // Both halves held, response slot free
   logic doRead; // Read address taken this cycle
   logic stepTick; // One-cycle pacing pulse
   logic capReady; // Applied code equals target
   logic [roc_pkg::EV_W-1:0] events; // Event pulses this cycle
   logic [roc_pkg::EV_W-1:0] clrMask; // Clear bits written this cycle
   logic [5:0] rdIdx;

   // Handshake outputs come straight from the holding flags
   assign awready = !awHeld_reg;
   assign wready = !wHeld_reg;
   assign arready = !rvalid_reg;
   assign bvalid = bvalid_reg;
   assign bresp = bresp_reg;
   assign rvalid = rvalid_reg;
   assign rdata = rdata_reg;
   assign rresp = rresp_reg;
   // Oscillator controls, all from flip-flops
   assign oscGainControlEn = ctrl_reg.gainEn;
   assign oscBiasDoubleEn = ctrl_reg.biasDouble;
   assign lowfreqOscSelect = ctrl_reg.lfoSel;
   assign oscCrystalModeSel = srcCrystal_reg;
   assign appliedLoadCap = applied_reg;
   assign crystalPinsShort = pinShort_reg;
   assign irq = irq_reg;

   // Amplitude detector sits in the analog domain, so synchronise it
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         ampMeta_reg <= 1'b0;
         ampSync_reg <= 1'b0;
         ampPrev_reg <= 1'b0;
         readyPrev_reg <= 1'b1;
      end
      else
      begin
         ampMeta_reg <= oscAmplitudeOk;
         ampSync_reg <= ampMeta_reg;
         ampPrev_reg <= ampSync_reg;
         readyPrev_reg <= capReady;
      end
   end

   // Bus decode and event detection
   always_comb
   begin
      doWrite = awHeld_reg && wHeld_reg && !bvalid_reg;
      doRead = arvalid && !rvalid_reg;
      rdIdx = roc_pkg::wordIndex(araddr);
      stepTick = (stepCnt_reg == roc_pkg::STEP_LAST);
      capReady = (applied_reg == cfg_reg.target);
      events = '0;
      events[roc_pkg::EV_CAP_READY] = capReady && !readyPrev_reg;
      events[roc_pkg::EV_AMP_UP] = ampSync_reg && !ampPrev_reg;
      events[roc_pkg::EV_AMP_LOST] = !ampSync_reg && ampPrev_reg;
      clrMask = '0;
      if (doWrite && wr_reg.lane0 && wr_reg.idx == roc_pkg::IRQ_CLR_IDX)
      begin
         clrMask = wr_reg.data[roc_pkg::EV_W-1:0];
      end
   end

   // Next register values: bus writes, stepping and interrupts
   always_comb
   begin
      ctrl_next = ctrl_reg;
      cfg_next = cfg_reg;
      pinShort_next = pinShort_reg;
      pinRsvd_next = pinRsvd_reg;
      irqEn_next = irqEn_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      // Response is dropped once the master has taken it
      if (bvalid_reg && bready)
      begin
         bvalid_next = 1'b0;
      end
      if (doWrite)
      begin
         bvalid_next = 1'b1;
         bresp_next = roc_pkg::RESP_OKAY;
         // Byte lane 0 carries the 8-bit registers; other lanes are ignored
         if (wr_reg.lane0)
         begin
            unique case (wr_reg.idx)
               roc_pkg::OSC_CTRL_IDX:
               begin
                  // Bits 4 and 2:0 are not stored, so they cannot change
                  ctrl_next.gainEn = wr_reg.data[roc_pkg::CTRL_GAIN_BIT];
                  ctrl_next.crystalMode = wr_reg.data[roc_pkg::CTRL_MODE_BIT];
                  ctrl_next.biasDouble = wr_reg.data[roc_pkg::CTRL_BIAS_BIT];
                  ctrl_next.lfoSel = wr_reg.data[roc_pkg::CTRL_LFO_BIT];
               end
               roc_pkg::OSC_CFG_IDX:
               begin
                  cfg_next.autoStep = wr_reg.data[roc_pkg::CFG_STEP_BIT];
                  cfg_next.target = wr_reg.data[3:0];
               end
               roc_pkg::PIN_CFG_IDX:
               begin
                  pinShort_next = wr_reg.data[roc_pkg::PIN_SHORT_BIT];
                  pinRsvd_next = wr_reg.data[6:0];
               end
               roc_pkg::IRQ_CLR_IDX:
               begin
                  // Handled through clrMask
               end
               roc_pkg::IRQ_EN_IDX:
               begin
                  irqEn_next = wr_reg.data[roc_pkg::EV_W-1:0];
               end
               default:
               begin
                  bresp_next = roc_pkg::RESP_SLVERR;
               end
            endcase
         end
      end
      // Source selection: the low-frequency oscillator overrides the mode bit
      srcCrystal_next = ctrl_next.crystalMode && !ctrl_next.lfoSel;
      // Stepping walks one code per tick; with stepping off the code jumps
      stepCnt_next = stepTick ? 8'h00 : stepCnt_reg + 8'h01;
      applied_next = applied_reg;
      if (!cfg_reg.autoStep)
      begin
         applied_next = cfg_reg.target;
         stepCnt_next = 8'h00;
      end
      else if (stepTick && !capReady)
      begin
         applied_next = (applied_reg < cfg_reg.target) ? applied_reg + 4'h1 : applied_reg - 4'h1;
      end
      // A new event beats a clear landing in the same cycle
      irqStat_next = (irqStat_reg & ~clrMask) | events;
      irq_next = |(irqStat_next & irqEn_next);
   end

   // Bus capture and read answer
   always_comb
   begin
      awHeld_next = awHeld_reg;
      wHeld_next = wHeld_reg;
      wr_next = wr_reg;
      // Address and data are taken in either order and held till the write
      if (awvalid && !awHeld_reg)
      begin
         awHeld_next = 1'b1;
         wr_next.idx = roc_pkg::wordIndex(awaddr);
      end
      if (wvalid && !wHeld_reg)
      begin
         wHeld_next = 1'b1;
         wr_next.data = wdata[7:0];
         wr_next.lane0 = wstrb[0];
      end
      if (doWrite)
      begin
         awHeld_next = 1'b0;
         wHeld_next = 1'b0;
      end
      rvalid_next = rvalid_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      if (rvalid_reg && rready)
      begin
         rvalid_next = 1'b0;
      end
      if (doRead)
      begin
         rvalid_next = 1'b1;
         rdata_next = 32'h0000_0000; // Unused and write-only bits read zero
         rresp_next = roc_pkg::RESP_OKAY;
         unique case (rdIdx)
            roc_pkg::OSC_CTRL_IDX:
            begin
               rdata_next[roc_pkg::CTRL_GAIN_BIT] = ctrl_reg.gainEn;
               rdata_next[roc_pkg::CTRL_MODE_BIT] = ctrl_reg.crystalMode;
               rdata_next[roc_pkg::CTRL_BIAS_BIT] = ctrl_reg.biasDouble;
               rdata_next[roc_pkg::CTRL_VALID_BIT] = ampSync_reg;
               rdata_next[roc_pkg::CTRL_LFO_BIT] = ctrl_reg.lfoSel;
            end
            roc_pkg::OSC_CFG_IDX:
            begin
               rdata_next[roc_pkg::CFG_STEP_BIT] = cfg_reg.autoStep;
               rdata_next[roc_pkg::CFG_READY_BIT] = capReady;
               rdata_next[3:0] = cfg_reg.target;
            end
            roc_pkg::PIN_CFG_IDX:
            begin
               rdata_next[6:0] = pinRsvd_reg; // short bit reads zero
            end
            roc_pkg::IRQ_STAT_IDX:
            begin
               rdata_next[roc_pkg::EV_W-1:0] = irqStat_reg;
            end
            roc_pkg::IRQ_CLR_IDX:
            begin
               // Write-only, reads zero
            end
            roc_pkg::IRQ_EN_IDX:
            begin
               rdata_next[roc_pkg::EV_W-1:0] = irqEn_reg;
            end
            default:
            begin
               rresp_next = roc_pkg::RESP_SLVERR;
            end
         endcase
      end
   end

   // Register every group
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         ctrl_reg <= '0;
         cfg_reg <= '{autoStep: 1'b0, target: roc_pkg::LOAD_CAP_RESET};
         pinShort_reg <= 1'b0;
         pinRsvd_reg <= roc_pkg::PIN_RSVD_RESET;
         irqStat_reg <= roc_pkg::IRQ_RESET;
         irqEn_reg <= roc_pkg::IRQ_RESET;
         applied_reg <= roc_pkg::LOAD_CAP_RESET;
         stepCnt_reg <= 8'h00;
         srcCrystal_reg <= 1'b0;
         irq_reg <= 1'b0;
         awHeld_reg <= 1'b0;
         wHeld_reg <= 1'b0;
         wr_reg <= '0;
         bvalid_reg <= 1'b0;
         bresp_reg <= roc_pkg::RESP_OKAY;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= roc_pkg::RESP_OKAY;
      end
      else
      begin
         ctrl_reg <= ctrl_next;
         cfg_reg <= cfg_next;
         pinShort_reg <= pinShort_next;
         pinRsvd_reg <= pinRsvd_next;
         irqStat_reg <= irqStat_next;
         irqEn_reg <= irqEn_next;
         applied_reg <= applied_next;
         stepCnt_reg <= stepCnt_next;
         srcCrystal_reg <= srcCrystal_next;
         irq_reg <= irq_next;
         awHeld_reg <= awHeld_next;
         wHeld_reg <= wHeld_next;
         wr_reg <= wr_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
      end
   end
endmodule : roc_osc_control
`default_nettype wire

// >>> verification/roc_osc_control_props.sv
// Checker for bus timing and oscillator outputs of the oscillator control block
`timescale 1ns/1ps
`default_nettype none
module roc_osc_control_props (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Write channels
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   input wire logic bready,
   // Read channels
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   input wire logic rready,
   // Oscillator side
   input wire logic oscAmplitudeOk,
   input wire logic oscCrystalModeSel,
   input wire logic lowfreqOscSelect
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // Both write halves taken at one edge
   sequence s_wrTaken; awvalid && awready && wvalid && wready; endsequence
   // Read address taken
   sequence s_rdTaken; arvalid && !rvalid; endsequence
   // Read of an index outside the map
   sequence s_rdBad; s_rdTaken ##0 (araddr[7:2] < 6'h05 || araddr[7:2] > 6'h0A); endsequence
   // Pin level held three samples, so the two-stage sync has settled
   sequence s_ampRead; $stable(oscAmplitudeOk)[*3] ##0 s_rdTaken ##0 (araddr[7:2] == 6'h05); endsequence
   property p_wrAnswer; s_wrTaken |-> ##[1:2] bvalid; endproperty
   // Readies are low in the cycle right after the take
   property p_wrBusy; s_wrTaken |=> !awready && !wready; endproperty
   property p_bHold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
   property p_rdAnswer; s_rdTaken |=> rvalid; endproperty
   property p_rHold; rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp) && !arready; endproperty
   property p_rdBad; s_rdBad |=> rresp == roc_pkg::RESP_SLVERR && rdata == 32'h0; endproperty
   property p_upperZero; rvalid |-> rdata[31:8] == 24'h0; endproperty
   property p_ampValid; s_ampRead |=> rdata[4] == $past(oscAmplitudeOk); endproperty
   property p_modeSel; lowfreqOscSelect |-> !oscCrystalModeSel; endproperty
   a_wrAnswer: assert property (p_wrAnswer) else $error("write not answered");
   a_wrBusy: assert property (p_wrBusy) else $error("write ready while write pending");
   a_bHold: assert property (p_bHold) else $error("write response dropped");
   a_rdAnswer: assert property (p_rdAnswer) else $error("read not answered");
   a_rHold: assert property (p_rHold) else $error("read response dropped");
   a_rdBad: assert property (p_rdBad) else $error("unmapped read not refused");
   a_upperZero: assert property (p_upperZero) else $error("upper read bits set");
   a_ampValid: assert property (p_ampValid) else $error("amplitude bit wrong");
   a_modeSel: assert property (p_modeSel) else $error("crystal mode with low-freq select");
endmodule : roc_osc_control_props
bind roc_osc_control roc_osc_control_props roc_osc_control_props_inst (.clk, .reset, .awvalid, .awready,
   .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
   .oscAmplitudeOk, .oscCrystalModeSel, .lowfreqOscSelect);
`default_nettype wire

// >>> verification/tb_roc_osc_control.sv
// Self-checking bench for the oscillator control block
`timescale 1ns/1ps
`default_nettype none
module tb_roc_osc_control;
   // Stimulus, all given at time zero
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hF;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic oscAmplitudeOk = 1'b0;
   // Design outputs
   logic awready, wready, bvalid, arready, rvalid, irq, crystalPinsShort;
   logic oscGainControlEn, oscCrystalModeSel, oscBiasDoubleEn, lowfreqOscSelect;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, rv;
   logic [3:0] appliedLoadCap;
   logic [1:0] rs;
   localparam logic [1:0] OK = roc_pkg::RESP_OKAY;
   localparam logic [1:0] ERR = roc_pkg::RESP_SLVERR;
   int badCount = 0;
   int testsRun = 0;
   always #2 clk = ~clk;
   roc_osc_control roc_osc_control_inst (.clk, .reset, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .oscAmplitudeOk, .oscGainControlEn, .oscCrystalModeSel, .oscBiasDoubleEn, .lowfreqOscSelect,
      .appliedLoadCap, .crystalPinsShort, .irq);
   // Verdict and end of run
   task automatic endOfTest;
      $display("Checks %0d, mismatches %0d", testsRun, badCount);
      if (badCount == 0 && testsRun > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : endOfTest
   // Value compare
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      testsRun++;
      if (got !== exp)
      begin
         badCount++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // A bounded wait ran out
   task automatic tmo;
      badCount++;
      $display("[ERR] %0t wait ran out", $time);
      endOfTest();
   endtask : tmo
   // Bus write; ready is late on purpose so the response must hold
   task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
      bit ta, tw, tk;
      @(posedge clk);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      tk = 0;
      for (int n = 0; n < 50 && !tk; n++)
      begin
         @(negedge clk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tk = bvalid && bready;
         r = bresp;
         @(posedge clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         bready <= !tk && n >= 2;
      end
      if (!tk) tmo();
   endtask : wr
   // Bus read, same late-ready habit
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      bit ta, tk;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      tk = 0;
      for (int n = 0; n < 50 && !tk; n++)
      begin
         @(negedge clk);
         ta = arvalid && arready;
         tk = rvalid && rready;
         d = rdata;
         r = rresp;
         @(posedge clk);
         if (ta) arvalid <= 1'b0;
         rready <= !tk && n >= 2;
      end
      if (!tk) tmo();
   endtask : rd
   task automatic wchk(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      wr(a, d, rs);
      chk({30'h0, rs}, {30'h0, er});
   endtask : wchk
   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      rd(a, rv, rs);
      chk(rv, e);
      chk({30'h0, rs}, {30'h0, er});
   endtask : rchk
   // Values after reset
   task automatic sReset;
      rchk(8'h14, 32'h0, OK);
      rchk(8'h18, 32'h40, OK);
      rchk(8'h1C, 32'h0, OK);
      chk({28'h0, appliedLoadCap}, 32'h0);
   endtask : sReset
   // Every control field, ending with all off
   task automatic sCtrl;
      logic [7:0] v[5] = '{8'hFF, 8'h40, 8'hA0, 8'h08, 8'h00};
      foreach (v[i])
      begin
         wchk(8'h14, v[i], OK);
         rchk(8'h14, {24'h0, v[i] & 8'hE8}, OK);
         chk({28'h0, oscGainControlEn, oscCrystalModeSel, oscBiasDoubleEn, lowfreqOscSelect},
            {28'h0, v[i][7], v[i][6] & !v[i][3], v[i][5], v[i][3]});
      end
   endtask : sCtrl
   // Amplitude flag and its interrupt: raise, clear, then masked
   task automatic sAmp;
      wchk(8'h28, 8'h02, OK);
      rchk(8'h28, 32'h2, OK);
      oscAmplitudeOk <= 1'b1;
      repeat (6) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      rchk(8'h14, 32'h10, OK);
      wchk(8'h24, 8'h02, OK);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      oscAmplitudeOk <= 1'b0;
      repeat (6) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      rd(8'h20, rv, rs);
      chk(rv & 32'h6, 32'h4);
      rchk(8'h14, 32'h0, OK);
   endtask : sAmp
   // Watches the applied code walk one step per interval to the target
   task automatic stepWatch(input logic [3:0] from, input logic [3:0] to);
      logic [3:0] p;
      int c;
      p = from;
      c = 0;
      for (int n = 0; n < 4000 && p != to; n++)
      begin
         @(negedge clk);
         c++;
         if (appliedLoadCap !== p)
         begin
            chk({28'h0, appliedLoadCap}, {28'h0, ((p < to) ? p + 4'h1 : p - 4'h1)});
            if (p != from) chk(c, roc_pkg::STEP_CYCLES);
            p = appliedLoadCap;
            c = 0;
         end
      end
      if (p != to) tmo();
   endtask : stepWatch
   // Direct load, then stepping down from F to 3 and back up to 5
   task automatic sCfg;
      wchk(8'h18, 8'h3F, OK);
      repeat (2) @(posedge clk);
      chk({28'h0, appliedLoadCap}, 32'hF);
      rchk(8'h18, 32'h4F, OK);
      wchk(8'h18, 8'h83, OK);
      rchk(8'h18, 32'h83, OK);
      // Clear the old reached event so only the end of this walk can set it
      wchk(8'h24, 8'h01, OK);
      stepWatch(4'hF, 4'h3);
      rchk(8'h18, 32'hC3, OK);
      rd(8'h20, rv, rs);
      chk(rv & 32'h1, 32'h1);
      wchk(8'h18, 8'h85, OK);
      rchk(8'h18, 32'h85, OK);
      stepWatch(4'h3, 4'h5);
      rchk(8'h18, 32'hC5, OK);
   endtask : sCfg
   // Pin short by read-modify-write
   task automatic sPin;
      wchk(8'h1C, 8'h85, OK);
      chk({31'h0, crystalPinsShort}, 32'h1);
      rd(8'h1C, rv, rs);
      chk(rv, 32'h05);
      wchk(8'h1C, rv[7:0] & 8'h7F, OK);
      chk({31'h0, crystalPinsShort}, 32'h0);
      rchk(8'h1C, 32'h05, OK);
   endtask : sPin
   // Unmapped places refused, write-only clear reads zero, lane 0 off is a no-op
   task automatic sBad;
      wchk(8'h30, 8'hFF, ERR);
      rchk(8'h30, 32'h0, ERR);
      rchk(8'h10, 32'h0, ERR);
      rchk(8'h24, 32'h0, OK);
      wstrb <= 4'hE;
      wchk(8'h14, 8'hFF, OK);
      wstrb <= 4'hF;
      rchk(8'h14, 32'h0, OK);
   endtask : sBad
   // Main sequence
   initial
   begin
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      sReset();
      sCtrl();
      sAmp();
      sCfg();
      sPin();
      sBad();
      endOfTest();
   end
endmodule : tb_roc_osc_control
`default_nettype wire
